//--- tic_time_interval_counter.v
// time interval counter: time-of-day chain and interval timer on the crystal clock
// What this block does
// - day-wrap bit: hours 0..23, else 0..255
// - two-bit field picks interval timebase
// - one-shot: timeout clears interval enable
// - periodic mode: reload counter each timeout
// - match sets sticky flag until cleared
// - interrupt request when flag and enabled
// - interval counter runs only while enabled
// - time clock gates all time and interval counter stepping, not the divider
// - clock disable restores last written values
// - time registers writable while clock off
// - control top bit ignored, reads zero
// - interval target 8-bit, resets to zero
// - fraction counts 0..127 at 128 Hz
// - interval steps each time the selected counter steps
// - seconds, minutes wrap 0..59 and carry
// - everything runs on the crystal clock
`include "tic_defines.vh"
module tic_time_interval_counter
#(
  parameter TICK_DIV = `TIC_TICK_DIV
)
(
  input  wire       clk,          // crystal clock domain
  input  wire       resetn,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  input  wire       int_enable,   // block interrupt enable from core
  output wire       int_request
);
  reg  [8:0] div_count;           // crystal divider
  reg  [6:0] control;             // bits 6..0 of control register
  reg  [7:0] interval_target;     // compare value
  reg  [7:0] interval_count;      // 8-bit interval counter
  reg        prev_clk_en;         // for clock-disable edge
  wire       tick;
  wire       run;
  wire [7:0] frac_q;
  wire [7:0] second_q;
  wire [7:0] min_q;
  wire [7:0] hour_q;
  wire       frac_wrap;
  wire       second_wrap;
  wire       min_wrap;
  wire       restore;
  wire       wr_ctl;
  wire       tb_step;
  wire       match;
  wire [7:0] hour_last;

  wire day_wrap_select       = control[`TIC_BIT_DAY_WRAP];
  wire timebase_select_hi    = control[`TIC_BIT_TB_HI];
  wire timebase_select_lo    = control[`TIC_BIT_TB_LO];
  wire one_shot_select       = control[`TIC_BIT_ONE_SHOT];
  wire interval_match_flag   = control[`TIC_BIT_MATCH];
  wire interval_count_enable = control[`TIC_BIT_INT_EN];
  wire time_clock_enable     = control[`TIC_BIT_CLK_EN];

  // 128 Hz tick from crystal divider, runs in power-down too
  always @(posedge clk)
  begin
    if (!resetn)
      div_count <= 9'h000;
    else if (div_count == TICK_DIV[8:0] - 9'h001)
      div_count <= 9'h000;
    else
      div_count <= div_count + 9'h001;
  end
  assign tick = (div_count == TICK_DIV[8:0] - 9'h001);

  // timebase reaches counters only while clock enabled
  assign run     = tick && time_clock_enable;
  assign restore = prev_clk_en && !time_clock_enable;
  assign wr_ctl  = sfr_wr && (sfr_addr == `TIC_ADDR_CONTROL);

  // hour wrap limit by mode
  assign hour_last = day_wrap_select ? `TIC_DAY_LAST : `TIC_FULL_LAST;

  // time writes accepted while clock is off
  wire wr_ok = sfr_wr && !time_clock_enable;

  tic_wrap_counter u_frac
  (
    .clk        (clk),
    .resetn     (resetn),
    .step       (run),
    .last       (`TIC_FRACTION_LAST),
    .load       (wr_ok && sfr_addr == `TIC_ADDR_FRACTION),
    .load_value (sfr_wdata),
    .restore    (restore),
    .count      (frac_q),
    .wrap       (frac_wrap)
  );
  tic_wrap_counter u_second
  (
    .clk        (clk),
    .resetn     (resetn),
    .step       (frac_wrap),
    .last       (`TIC_SIXTY_LAST),
    .load       (wr_ok && sfr_addr == `TIC_ADDR_SECOND),
    .load_value (sfr_wdata),
    .restore    (restore),
    .count      (second_q),
    .wrap       (second_wrap)
  );
  tic_wrap_counter u_min
  (
    .clk        (clk),
    .resetn     (resetn),
    .step       (second_wrap),
    .last       (`TIC_SIXTY_LAST),
    .load       (wr_ok && sfr_addr == `TIC_ADDR_MINUTE),
    .load_value (sfr_wdata),
    .restore    (restore),
    .count      (min_q),
    .wrap       (min_wrap)
  );
  // hour overflow feeds nothing: there is no day counter
  tic_wrap_counter u_hour
  (
    .clk        (clk),
    .resetn     (resetn),
    .step       (min_wrap),
    .last       (hour_last),
    .load       (wr_ok && sfr_addr == `TIC_ADDR_HOUR),
    .load_value (sfr_wdata),
    .restore    (restore),
    .count      (hour_q),
    .wrap       ()
  );

  // timebase pick: step of selected register
  reg tb_pick;
  always @*
  begin
    case ({timebase_select_hi, timebase_select_lo})
      `TIC_TB_FRACTION: tb_pick = run;
      `TIC_TB_SECOND:   tb_pick = frac_wrap;
      `TIC_TB_MINUTE:   tb_pick = second_wrap;
      `TIC_TB_HOUR:     tb_pick = min_wrap;
      default:          tb_pick = 1'b0;
    endcase
  end
  assign tb_step = tb_pick && interval_count_enable;

  // match when stepped counter reaches target
  assign match = tb_step && (interval_count + 8'h01 == interval_target);

  // interval counter: reload on timeout, clear when disabled
  always @(posedge clk)
  begin
    if (!resetn)
      interval_count <= 8'h00;
    else if (match)
      interval_count <= 8'h00;
    else if (tb_step)
      interval_count <= interval_count + 8'h01;
    else if (!interval_count_enable)
      interval_count <= 8'h00;
  end

  // control register: match sets win over clears
  always @(posedge clk)
  begin
    if (!resetn)
      control <= 7'h00;
    else
    begin
      if (wr_ctl)
        control <= sfr_wdata[6:0];
      if (match)
      begin
        control[`TIC_BIT_MATCH] <= 1'b1;
        if (one_shot_select)
          control[`TIC_BIT_INT_EN] <= 1'b0;
      end
    end
  end

  // target register and clock-enable history
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      interval_target <= `TIC_RESET_VALUE;
      prev_clk_en     <= 1'b0;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `TIC_ADDR_TARGET)
        interval_target <= sfr_wdata;
      prev_clk_en <= time_clock_enable;
    end
  end

  // read data registered
  always @(posedge clk)
  begin
    if (!resetn)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `TIC_ADDR_CONTROL:  sfr_rdata <= {1'b0, control};
        `TIC_ADDR_FRACTION: sfr_rdata <= frac_q;
        `TIC_ADDR_SECOND:   sfr_rdata <= second_q;
        `TIC_ADDR_MINUTE:   sfr_rdata <= min_q;
        `TIC_ADDR_HOUR:     sfr_rdata <= hour_q;
        `TIC_ADDR_TARGET:   sfr_rdata <= interval_target;
        default:            sfr_rdata <= 8'h00;
      endcase
    end
  end

  // interrupt request level
  assign int_request = interval_match_flag && int_enable;
endmodule // tic_time_interval_counter

//--- tic_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef TIC_DEFINES_VH
`define TIC_DEFINES_VH
`define TIC_ADDR_CONTROL     8'hA1
`define TIC_ADDR_FRACTION    8'hA2
`define TIC_ADDR_SECOND      8'hA3
`define TIC_ADDR_MINUTE      8'hA4
`define TIC_ADDR_HOUR        8'hA5
`define TIC_ADDR_TARGET      8'hA6
`define TIC_BIT_DAY_WRAP     6
`define TIC_BIT_TB_HI        5
`define TIC_BIT_TB_LO        4
`define TIC_BIT_ONE_SHOT     3
`define TIC_BIT_MATCH        2
`define TIC_BIT_INT_EN       1
`define TIC_BIT_CLK_EN       0
`define TIC_RESET_VALUE      8'h00
`define TIC_FRACTION_LAST    8'h7F
`define TIC_SIXTY_LAST       8'h3B
`define TIC_DAY_LAST         8'h17
`define TIC_FULL_LAST        8'hFF
`define TIC_TB_FRACTION      2'h0
`define TIC_TB_SECOND        2'h1
`define TIC_TB_MINUTE        2'h2
`define TIC_TB_HOUR          2'h3
`define TIC_XTAL_HZ          32768
`define TIC_TICK_HZ          128
`define TIC_TICK_DIV         (`TIC_XTAL_HZ / `TIC_TICK_HZ)
`endif

//--- tic_wrap_counter.v
// one wrapping time counter with a software shadow value
`include "tic_defines.vh"
module tic_wrap_counter
(
  input  wire       clk,
  input  wire       resetn,
  input  wire       step,
  input  wire [7:0] last,
  input  wire       load,
  input  wire [7:0] load_value,
  input  wire       restore,
  output reg  [7:0] count,
  output wire       wrap
);
  reg [7:0] shadow;   // value software last wrote

  // wrap pulse when stepping from the last value
  assign wrap = step && (count == last);

  // shadow keeps the written value for restore
  always @(posedge clk)
  begin
    if (!resetn)
      shadow <= `TIC_RESET_VALUE;
    else if (load)
      shadow <= load_value;
  end

  // counter: write, restore, or step
  always @(posedge clk)
  begin
    if (!resetn)
      count <= `TIC_RESET_VALUE;
    else if (load)
      count <= load_value;
    else if (restore)
      count <= shadow;
    else if (wrap)
      count <= 8'h00;
    else if (step)
      count <= count + 8'h01;
  end
endmodule // tic_wrap_counter

//--- tic_sva.sv
// port checker for the time interval counter
module tic_sva
(
  input wire       clk,
  input wire       resetn,
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire       int_enable,
  input wire       int_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // write and read of target and control, read of second or minute
  sequence s_tw; sfr_wr && sfr_addr == 8'hA6; endsequence
  sequence s_tr; sfr_rd && sfr_addr == 8'hA6; endsequence
  sequence s_cw; sfr_wr && sfr_addr == 8'hA1; endsequence
  sequence s_cr; sfr_rd && sfr_addr == 8'hA1; endsequence
  sequence s_sm; sfr_rd && (sfr_addr == 8'hA3 || sfr_addr == 8'hA4); endsequence
  a_target_readback: assert property (s_tw ##2 s_tr |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("target readback wrong");
  a_control_fields: assert property (s_cw ##2 s_cr
    |=> sfr_rdata[6:3] == $past(sfr_wdata[6:3], 3))
    else $error("control field readback wrong");
  a_reset_clear: assert property (disable iff (1'b0) !resetn
    |=> sfr_rdata == 8'h00 && !int_request)
    else $error("outputs not clear after reset");
  a_irq_gate: assert property (!int_enable |-> !int_request)
    else $error("request while disabled");
  a_flag_sticky: assert property (int_request && !(sfr_wr && sfr_addr == 8'hA1)
    |=> int_request || !int_enable)
    else $error("flag dropped without write");
  a_ctl_top_bit: assert property (s_cr |=> !sfr_rdata[7])
    else $error("control top bit set");
  a_frac_range: assert property (sfr_rd && sfr_addr == 8'hA2 |=> sfr_rdata <= 8'h7F)
    else $error("fraction out of range");
  a_sixty_range: assert property (s_sm |=> sfr_rdata <= 8'h3B)
    else $error("second or minute out of range");
endmodule // tic_sva
bind tic_time_interval_counter tic_sva u_sva (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .int_enable(int_enable), .int_request(int_request));

//--- time_interval_counter_tb_top.sv
// self-checking bench for the time interval counter
module time_interval_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg        clk = 1'b0;
  reg        resetn = 1'b0;
  reg  [7:0] sfr_addr = 8'h00;
  reg        sfr_wr = 1'b0;
  reg  [7:0] sfr_wdata = 8'h00;
  reg        sfr_rd = 1'b0;
  wire [7:0] sfr_rdata;
  reg        int_enable = 1'b1;
  wire       int_request;
  integer    seed = 15584;
  integer    miscompares = 0;
  integer    checked = 0;
  integer    cyc = 0;
  integer    i, n, t;
  reg  [7:0] v, r, f;
  tic_time_interval_counter #(.TICK_DIV(4)) DUT (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .int_enable(int_enable), .int_request(int_request));
  initial forever #5 clk = ~clk;
  // clocks per interval step for the fraction, second and minute timebases
  function integer per(input integer tb);
    per = (tb == 0) ? 4 : (tb == 1) ? 512 : 30720;
  endfunction
  // expected hour after one roll-over in either wrap mode
  function [7:0] hr(input [7:0] h, input dw);
    hr = (dw && h == 8'h17) ? 8'h00 : h + 8'h01;
  endfunction
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      sfr_addr <= a;
      sfr_wr <= 1'b1;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] q);
    begin
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 q = sfr_rdata;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  // cycles until the request shows, bounded
  task wi(output integer c);
    begin
      c = 0;
      #1;
      while (int_request !== 1'b1 && c < 35000)
      begin
        @(posedge clk);
        #1 c = c + 1;
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 50000)
    begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (i = 1; i < 7; i++)
    begin
      rd(8'hA0 + i, r);
      chk(r, 8'h00);
    end
    v = $random(seed);
    wr(8'hA6, v);
    rd(8'hA6, r);
    chk(r, v);
    v = $random(seed) & 8'hFA;
    wr(8'hA1, v);
    rd(8'hA1, r);
    chk(r, v & 8'h7A);
    wr(8'hA1, 8'h00);
    // stopped: writes stick and nothing advances
    for (i = 2; i < 6; i++)
    begin
      v = {$random(seed)} % 24;
      wr(8'hA0 + i, v);
      repeat (20) @(posedge clk);
      rd(8'hA0 + i, r);
      chk(r, v);
    end
    f = {$random(seed)} % 64;
    wr(8'hA2, f);
    wr(8'hA3, 8'h00);
    wr(8'hA4, 8'h00);
    wr(8'hA1, 8'h01);
    repeat (40) @(posedge clk);
    rd(8'hA2, r);
    chk({7'h00, r > f + 8 && r < f + 13}, 8'h01);
    wr(8'hA1, 8'h00);
    rd(8'hA2, r);
    chk(r, f);
    wr(8'hA2, 8'h00);
    // one-shot interval on each short timebase
    for (t = 0; t < 3; t++)
    begin
      v = (t == 0) ? 8'h02 + {$random(seed)} % 8 : 8'h01;
      wr(8'hA6, v);
      wr(8'hA1, {2'b00, t[1:0], 4'hB});
      wi(n);
      chk({7'h00, n + 3 >= v * per(t) && n <= v * per(t)}, 8'h01);
      rd(8'hA1, r);
      chk(r, {2'b00, t[1:0], 4'hD});
      @(posedge clk);
      int_enable <= 1'b0;
      @(posedge clk);
      #1 chk({7'h00, int_request}, 8'h00);
      @(posedge clk);
      int_enable <= 1'b1;
      wr(8'hA1, 8'h00);
    end
    // periodic mode keeps firing, then stops when disabled
    wr(8'hA6, 8'h03);
    wr(8'hA1, 8'h03);
    wi(n);
    wr(8'hA1, 8'h03);
    wi(n);
    chk({7'h00, n >= 8 && n <= 12 && int_request}, 8'h01);
    wr(8'hA1, 8'h01);
    repeat (40) @(posedge clk);
    #1 chk({7'h00, int_request}, 8'h00);
    // chain preloaded one tick short of an hour roll-over, hour timebase
    for (t = 0; t < 4; t++)
    begin
      f = t[1] ? 8'h17 : t[0] ? {$random(seed)} % 23 : 8'hFF;
      wr(8'hA1, 8'h00);
      wr(8'hA2, 8'h7F);
      wr(8'hA3, 8'h3B);
      wr(8'hA4, 8'h3B);
      wr(8'hA5, f);
      wr(8'hA6, 8'h01);
      wr(8'hA1, {1'b0, t[0], 6'h3B});
      wi(n);
      chk({7'h00, n >= 1 && n <= per(0)}, 8'h01);
      wr(8'hA4, 8'h05);
      rd(8'hA4, r);
      chk(r, 8'h00);
      rd(8'hA5, r);
      chk(r, hr(f, t[0]));
    end
    wr(8'hA1, 8'h00);
    // mid-run reset returns the registers to zero
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'hA6, r);
    chk(r, 8'h00);
    rd(8'hA1, r);
    chk(r, 8'h00);
    end_of_test;
  end
endmodule // time_interval_counter_tb_top
